// [acp_host.sv]
// Host end: Avalon-MM controlled writer of serial configuration words
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module acp_host #(
  parameter int SCLK_HALF = acp_pkg::SCLK_HALF_CYC,
  parameter int RST_PULSE = acp_pkg::RESET_PULSE_CYC
) (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // Avalon-MM slave
  input  wire logic [acp_pkg::CSR_ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest,
  // Pins to the device
  acp_if.host                                link
);

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LO, H_HI, H_END, H_RST} acp_host_st_t;

  typedef struct packed {
    acp_host_st_t                  st;
    logic                          waitreq;
    logic [31:0]                   rdata;
    logic [acp_pkg::WORD_BITS-1:0] shift;
    logic [acp_pkg::CNT_W-1:0]     bitcnt;
    logic                          hold;
    logic [acp_pkg::DIV_W-1:0]     div;
    logic                          cs_n;
    logic                          sclk;
    logic                          sdo;
    logic                          rst_n;
    logic                          pd;
  } acp_host_state_t;

  acp_host_state_t s_r;
  acp_host_state_t s_nxt;
  logic            tick;
  logic            rst_done;
  logic            req;

  assign tick     = (s_r.div == acp_pkg::DIV_W'(SCLK_HALF - 1));
  assign rst_done = (s_r.div == acp_pkg::DIV_W'(RST_PULSE - 1));
  assign req      = (avs_read | avs_write) & s_r.waitreq;

  ////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.waitreq = 1'b1;
    s_nxt.div     = s_r.div + acp_pkg::DIV_W'(1);

    // Register access; command and reset writes stall while busy
    if (req && avs_read) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata   = '0;
      if (avs_address == acp_pkg::CSR_CTRL) begin
        s_nxt.rdata[acp_pkg::CTRL_PD_BIT] = s_r.pd;
      end else if (avs_address == acp_pkg::CSR_STATUS) begin
        s_nxt.rdata[acp_pkg::STAT_BUSY_BIT] = (s_r.st != H_IDLE);
        s_nxt.rdata[acp_pkg::STAT_CS_BIT]   = ~s_r.cs_n;
      end
    end else if (req && avs_write) begin
      if (avs_address == acp_pkg::CSR_CMD) begin
        if (s_r.st == H_IDLE) begin
          s_nxt.waitreq = 1'b0;
          s_nxt.shift   = avs_writedata[acp_pkg::WORD_BITS-1:0];
          s_nxt.hold    = avs_writedata[acp_pkg::CMD_HOLD_BIT];
          s_nxt.bitcnt  = '0;
          s_nxt.div     = '0;
          s_nxt.cs_n    = 1'b0;
          s_nxt.st      = (s_r.cs_n) ? H_SETUP : H_LO;
        end
      end else if (avs_address == acp_pkg::CSR_CTRL) begin
        if (s_r.st == H_IDLE) begin
          s_nxt.waitreq = 1'b0;
          s_nxt.pd      = avs_writedata[acp_pkg::CTRL_PD_BIT];
          if (avs_writedata[acp_pkg::CTRL_HWRST_BIT]) begin
            s_nxt.rst_n = 1'b0;
            s_nxt.div   = '0;
            s_nxt.st    = H_RST;
          end
        end
      end else begin
        s_nxt.waitreq = 1'b0;
      end
    end

    // Serial sequencer
    unique case (s_r.st)
      H_IDLE: begin
      end
      H_SETUP: begin
        if (tick) begin
          s_nxt.div = '0;
          s_nxt.st  = H_LO;
        end
      end
      H_LO: begin
        s_nxt.sdo = s_r.shift[acp_pkg::WORD_BITS-1];
        if (tick) begin
          s_nxt.div  = '0;
          s_nxt.sclk = 1'b1;
          s_nxt.st   = H_HI;
        end
      end
      H_HI: begin
        if (tick) begin
          s_nxt.div    = '0;
          s_nxt.sclk   = 1'b0;
          s_nxt.shift  = {s_r.shift[acp_pkg::WORD_BITS-2:0], 1'b0};
          s_nxt.bitcnt = s_r.bitcnt + acp_pkg::CNT_W'(1);
          if (s_r.bitcnt == acp_pkg::CNT_W'(acp_pkg::WORD_BITS - 1)) begin
            s_nxt.st = (s_r.hold) ? H_IDLE : H_END;
          end else begin
            s_nxt.st = H_LO;
          end
        end
      end
      H_END: begin
        if (tick) begin
          s_nxt.cs_n = 1'b1;
          s_nxt.st   = H_IDLE;
        end
      end
      H_RST: begin
        if (rst_done) begin
          s_nxt.rst_n = 1'b1;
          s_nxt.st    = H_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r         <= '0;
      s_r.st      <= H_IDLE;
      s_r.waitreq <= 1'b1;
      s_r.cs_n    <= 1'b1;
      s_r.rst_n   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  assign avs_readdata           = s_r.rdata;
  assign avs_waitrequest        = s_r.waitreq;
  assign link.cs_n              = s_r.cs_n;
  assign link.sclk              = s_r.sclk;
  assign link.serial_write_line = s_r.sdo;
  assign link.reset_n           = s_r.rst_n;
  assign link.powerdown_pin     = s_r.pd;

endmodule : acp_host
`default_nettype wire

// [acp_pkg.sv]
// Shared constants of the serial configuration port, both ends
package acp_pkg;

  // Word format
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int WORD_BITS = 24;
  localparam int CNT_W     = 5;
  localparam int SYNC_W    = 2;

  // Device register addresses and fields
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [7:0]  REG_POWER        = 8'h0F;
  localparam int          RST_BIT          = 0;
  localparam int          PDN_CH_LSB       = 0;
  localparam int          PDN_CH_W         = 8;
  localparam int          PDN_PARTIAL_BIT  = 8;
  localparam int          PDN_COMPLETE_BIT = 9;
  localparam int          PDN_PIN_CFG_BIT  = 10;
  localparam logic [15:0] POWER_DEFAULT    = 16'h0000;

  // System clock
  localparam int CLK_MHZ       = 50;
  localparam int CLK_PERIOD_NS = 20;

  // Wake-up times, longest times rounded down
  localparam int WAKE_W            = 12;
  localparam int WAKE_COMPLETE_US  = 50;
  localparam int WAKE_PARTIAL_US   = 2;
  localparam int WAKE_COMPLETE_CYC = WAKE_COMPLETE_US * CLK_MHZ;
  localparam int WAKE_PARTIAL_CYC  = WAKE_PARTIAL_US * CLK_MHZ;

  // Host timing: reset pulse must exceed 100 ns, serial clock at most 20 MHz
  localparam int RESET_PULSE_NS   = 100;
  localparam int RESET_PULSE_CYC  = RESET_PULSE_NS / CLK_PERIOD_NS + 1;
  localparam int SCLK_MIN_NS      = 50;
  localparam int SCLK_HALF_NS     = 80;
  localparam int SCLK_HALF_CYC    = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int DIV_W            = 8;

  // Host control registers on Avalon-MM
  localparam int         CSR_ADDR_W      = 4;
  localparam logic [3:0] CSR_CMD         = 4'h0;
  localparam logic [3:0] CSR_CTRL        = 4'h4;
  localparam logic [3:0] CSR_STATUS      = 4'h8;
  localparam int         CMD_HOLD_BIT    = 24;
  localparam int         CTRL_PD_BIT     = 0;
  localparam int         CTRL_HWRST_BIT  = 1;
  localparam int         STAT_BUSY_BIT   = 0;
  localparam int         STAT_CS_BIT     = 1;

endpackage : acp_pkg

// [acp_if.sv]
// Pins between the host controller and the configuration port
`timescale 1ns/1ns
`default_nettype none
interface acp_if;
  logic cs_n;
  logic sclk;
  logic serial_write_line;
  logic reset_n;
  logic powerdown_pin;

  modport dev (
    input cs_n,
    input sclk,
    input serial_write_line,
    input reset_n,
    input powerdown_pin
  );

  modport host (
    output cs_n,
    output sclk,
    output serial_write_line,
    output reset_n,
    output powerdown_pin
  );
endinterface : acp_if
`default_nettype wire

// [acp_dev.sv]
// Device end: serial word receiver, reset handling and power-down control
// Functional notes
// - Shift only while select is low
// - Sample data on serial clock rising edges
// - Commit word on every 24th rising edge
// - Discard trailing partial word at select rise
// - Several words per select, each committed
// - Eight address bits, then sixteen data bits
// - Any clock rate up to 20 MHz
// - Host resets registers after power-up
// - Low reset pin restores register defaults
// - Software reset bit restores defaults, self-clears
// - Host rewrites initialization registers after reset
// - Complete and register-selected partial power-down
// - Valid data within 50 us after complete
// - Valid data within 2 us after partial; 50 us here if the sampling clock stopped during it
`timescale 1ns/1ns
`default_nettype none
module acp_dev (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Pins from the host
  acp_if.dev                               link,
  // Sampling clock status
  input  wire logic                        sample_clk_running,
  // Committed words
  output logic                             wr_valid,
  output logic [acp_pkg::ADDR_W-1:0]       wr_addr,
  output logic [acp_pkg::DATA_W-1:0]       wr_data,
  output logic                             defaults_load,
  // Power state
  output logic [acp_pkg::PDN_CH_W-1:0]     pdn_ch,
  output logic                             pd_complete,
  output logic                             pd_partial,
  output logic                             data_valid
);

  typedef struct packed {
    logic [acp_pkg::SYNC_W-1:0]    cs_sy;
    logic [acp_pkg::SYNC_W-1:0]    sclk_sy;
    logic [acp_pkg::SYNC_W-1:0]    sd_sy;
    logic [acp_pkg::SYNC_W-1:0]    rn_sy;
    logic [acp_pkg::SYNC_W-1:0]    pd_sy;
    logic                          sclk_d;
    logic [acp_pkg::WORD_BITS-2:0] shift;
    logic [acp_pkg::CNT_W-1:0]     cnt;
    logic [acp_pkg::DATA_W-1:0]    power;
    logic                          wr_valid;
    logic [acp_pkg::ADDR_W-1:0]    wr_addr;
    logic [acp_pkg::DATA_W-1:0]    wr_data;
    logic                          defaults_load;
    logic                          pd_complete;
    logic                          pd_partial;
    logic                          clk_lost;
    logic [acp_pkg::WAKE_W-1:0]    wake_cnt;
    logic                          data_valid;
  } acp_dev_state_t;

  acp_dev_state_t s_r;
  acp_dev_state_t s_nxt;

  logic                            cs_n_s;
  logic                            sclk_s;
  logic                            sd_s;
  logic                            rn_s;
  logic                            pd_s;
  logic                            rise;
  logic [acp_pkg::WORD_BITS-1:0]   word;
  logic                            complete;
  logic                            partial;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Synchronised pins, second stage only
  assign cs_n_s = s_r.cs_sy[1];
  assign sclk_s = s_r.sclk_sy[1];
  assign sd_s   = s_r.sd_sy[1];
  assign rn_s   = s_r.rn_sy[1];
  assign pd_s   = s_r.pd_sy[1];

  // Edge found by oversampling, so no minimum rate applies
  assign rise = sclk_s & ~s_r.sclk_d;
  assign word = {s_r.shift, sd_s};

  ////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.cs_sy   = {s_r.cs_sy[0], link.cs_n};
    s_nxt.sclk_sy = {s_r.sclk_sy[0], link.sclk};
    s_nxt.sd_sy   = {s_r.sd_sy[0], link.serial_write_line};
    s_nxt.rn_sy   = {s_r.rn_sy[0], link.reset_n};
    s_nxt.pd_sy   = {s_r.pd_sy[0], link.powerdown_pin};
    s_nxt.sclk_d  = sclk_s;
    s_nxt.wr_valid      = 1'b0;
    s_nxt.defaults_load = 1'b0;

    // Serial receiver
    if (cs_n_s) begin
      s_nxt.cnt = '0;
    end else if (rise) begin
      s_nxt.shift = word[acp_pkg::WORD_BITS-2:0];
      if (s_r.cnt == acp_pkg::CNT_W'(acp_pkg::WORD_BITS - 1)) begin
        s_nxt.cnt      = '0;
        s_nxt.wr_valid = 1'b1;
        s_nxt.wr_addr  = word[acp_pkg::WORD_BITS-1 -: acp_pkg::ADDR_W];
        s_nxt.wr_data  = word[acp_pkg::DATA_W-1:0];
        if (word[acp_pkg::WORD_BITS-1 -: acp_pkg::ADDR_W] == acp_pkg::REG_RESET) begin
          // Reset bit is never stored, so it reads back as cleared
          if (word[acp_pkg::RST_BIT]) begin
            s_nxt.power         = acp_pkg::POWER_DEFAULT;
            s_nxt.defaults_load = 1'b1;
          end
        end else if (word[acp_pkg::WORD_BITS-1 -: acp_pkg::ADDR_W] == acp_pkg::REG_POWER) begin
          s_nxt.power = word[acp_pkg::DATA_W-1:0];
        end
      end else begin
        s_nxt.cnt = s_r.cnt + acp_pkg::CNT_W'(1);
      end
    end

    // Hardware reset pin overrides a write in the same cycle
    if (!rn_s) begin
      s_nxt.power         = acp_pkg::POWER_DEFAULT;
      s_nxt.defaults_load = 1'b1;
    end

    // Power-down: pin selects complete unless configured for partial
    complete = s_r.power[acp_pkg::PDN_COMPLETE_BIT]
             | (pd_s & ~s_r.power[acp_pkg::PDN_PIN_CFG_BIT]);
    partial  = ~complete & (s_r.power[acp_pkg::PDN_PARTIAL_BIT]
             | (pd_s & s_r.power[acp_pkg::PDN_PIN_CFG_BIT]));
    s_nxt.pd_complete = complete;
    s_nxt.pd_partial  = partial;

    if (partial && !sample_clk_running) begin
      s_nxt.clk_lost = 1'b1;
    end
    if (complete) begin
      s_nxt.wake_cnt = acp_pkg::WAKE_W'(acp_pkg::WAKE_COMPLETE_CYC);
    end else if (partial) begin
      // Stopped sampling clock costs the slow recovery
      s_nxt.wake_cnt = (s_nxt.clk_lost) ? acp_pkg::WAKE_W'(acp_pkg::WAKE_COMPLETE_CYC)
                                        : acp_pkg::WAKE_W'(acp_pkg::WAKE_PARTIAL_CYC);
    end else if (s_r.wake_cnt != '0) begin
      s_nxt.wake_cnt = s_r.wake_cnt - acp_pkg::WAKE_W'(1);
      if (s_r.wake_cnt == acp_pkg::WAKE_W'(1)) begin
        s_nxt.clk_lost = 1'b0;
      end
    end
    s_nxt.data_valid = ~complete & ~partial & (s_r.wake_cnt <= acp_pkg::WAKE_W'(1));
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // Synchronisers start at the idle pin levels, so no false select or reset follows rst
      s_r       <= '0;
      s_r.cs_sy <= '1;
      s_r.rn_sy <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  assign wr_valid      = s_r.wr_valid;
  assign wr_addr       = s_r.wr_addr;
  assign wr_data       = s_r.wr_data;
  assign defaults_load = s_r.defaults_load;
  assign pdn_ch        = s_r.power[acp_pkg::PDN_CH_LSB +: acp_pkg::PDN_CH_W];
  assign pd_complete   = s_r.pd_complete;
  assign pd_partial    = s_r.pd_partial;
  assign data_valid    = s_r.data_valid;

endmodule : acp_dev
`default_nettype wire

// [acp_props.sv]
// Checker of the link between the host and device ends
`timescale 1ns/1ns
`default_nettype none
module acp_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_write_line,
  input wire logic reset_n,
  // Device outputs
  input wire logic wr_valid,
  input wire logic defaults_load,
  input wire logic pd_complete,
  input wire logic pd_partial,
  input wire logic data_valid,
  // Sampling clock status
  input wire logic sample_clk_running
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic        sclk_r;
  logic [4:0]  cnt_r;
  logic [11:0] wake_r;
  logic        lost_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Rising edges of the serial clock within a word, cycles spent waking
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_r <= 1'b0;
      cnt_r  <= 5'h00;
      wake_r <= 12'h000;
      lost_r <= 1'b0;
    end else begin
      sclk_r <= sclk;
      // Partial power-down with a stopped sampling clock is exempt from the fast wake
      if (pd_partial && !sample_clk_running) begin
        lost_r <= 1'b1;
      end else if (data_valid) begin
        lost_r <= 1'b0;
      end
      if (cs_n) begin
        cnt_r <= 5'h00;
      end else if (sclk && !sclk_r) begin
        cnt_r <= (cnt_r == 5'h17) ? 5'h00 : cnt_r + 5'h01;
      end
      wake_r <= (pd_complete || pd_partial || data_valid) ? 12'h000 : wake_r + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sel_quiet_a: assert property (cs_n [*8] |-> !wr_valid)
    else $error("word committed while deselected");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock moves while deselected");
  cs_setup_a: assert property ($fell(cs_n) |-> !sclk [*4])
    else $error("serial clock rises too soon after select");
  bit_hold_a: assert property ($rose(sclk) |-> $stable(serial_write_line) [*4])
    else $error("data changes around the sampling edge");
  clk_half_a: assert property ($rose(sclk) |-> sclk [*3])
    else $error("serial clock high time too short");
  commit_time_a: assert property ((!cs_n && sclk && !sclk_r && cnt_r == 5'h17) |-> ##[1:6] wr_valid)
    else $error("no commit after the last bit of a word");
  commit_count_a: assert property (wr_valid |-> cnt_r == 5'h00)
    else $error("commit not on a word boundary");
  pd_mode_a: assert property (!(pd_complete && pd_partial))
    else $error("both power-down modes at once");
  wake_full_a: assert property (wake_r <= 12'h9c5)
    else $error("wake from complete power-down too slow");
  wake_part_a: assert property (($fell(pd_partial) && !pd_complete && !lost_r) |-> ##[1:103] data_valid)
    else $error("wake from partial power-down too slow");
  hw_reset_a: assert property ($fell(reset_n) |-> ##[1:6] defaults_load)
    else $error("reset pin did not load defaults");
endmodule : acp_props
`default_nettype wire

// [acp_tb.sv]
// Testbench joining host and device ends over the link
`timescale 1ns/1ns
`default_nettype none
module acp_tb;
  logic        clk_sys;
  logic        rst;
  logic        rst_host;
  logic        sclk_run;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        wr_valid;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;
  logic        defaults_load;
  logic [7:0]  pdn_ch;
  logic        pd_complete;
  logic        pd_partial;
  logic        data_valid;
  logic [31:0] q;
  logic [15:0] d;
  logic [7:0]  a;
  logic        h;
  logic [23:0] exp_q[$];
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          dl_n = 0;
  int          n;

  acp_if lnk ();
  acp_host i_acp_host (.clk_sys(clk_sys), .rst(rst_host), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(lnk));
  acp_dev i_acp_dev (.clk_sys(clk_sys), .rst(rst), .link(lnk), .sample_clk_running(sclk_run),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .defaults_load(defaults_load),
    .pdn_ch(pdn_ch), .pd_complete(pd_complete), .pd_partial(pd_partial), .data_valid(data_valid));
  acp_props i_acp_props (.clk_sys(clk_sys), .rst(rst), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
    .serial_write_line(lnk.serial_write_line), .reset_n(lnk.reset_n), .wr_valid(wr_valid),
    .defaults_load(defaults_load), .pd_complete(pd_complete), .pd_partial(pd_partial),
    .data_valid(data_valid), .sample_clk_running(sclk_run));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // One bus cycle, held until waitrequest is seen low
  task automatic av(input logic rd, input logic [3:0] ad, input logic [31:0] wd, output logic [31:0] rdata);
    avs_address   <= ad;
    avs_writedata <= wd;
    avs_read      <= rd;
    avs_write     <= !rd;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : av

  task automatic word(input logic [7:0] wa, input logic [15:0] wd, input logic hold);
    logic [31:0] r;
    if (wa != acp_pkg::REG_RESET) exp_q.push_back({wa, wd});
    av(1'b0, acp_pkg::CSR_CMD, {7'h00, hold, wa, wd}, r);
  endtask : word

  task automatic idle();
    logic [31:0] r;
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) av(1'b1, acp_pkg::CSR_STATUS, 32'h0000_0000, r);
    repeat (8) @(posedge clk_sys);
  endtask : idle

  function automatic int wake_exp(input logic complete);
    return complete ? acp_pkg::WAKE_COMPLETE_CYC : acp_pkg::WAKE_PARTIAL_CYC;
  endfunction : wake_exp

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Committed words against the queue, reset loads counted
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      wrap_up();
    end
    if (defaults_load === 1'b1) dl_n = dl_n + 1;
    if (wr_valid === 1'b1 && wr_addr !== acp_pkg::REG_RESET) begin
      if (exp_q.size() == 0) chk("stray word", 32'h1, 32'h0);
      else chk("word", {wr_addr, wr_data}, exp_q.pop_front());
    end
  end

  initial begin
    rst = 1'b1;
    rst_host = 1'b1;
    sclk_run = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    void'($urandom(32'h5abf_e32a));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rst_host <= 1'b0;
    @(posedge clk_sys);
    av(1'b1, 4'hc, 32'h0000_0000, q);
    chk("unmapped", q, 32'h0000_0000);
    av(1'b0, acp_pkg::CSR_CTRL, 32'h0000_0002, q);
    idle();
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($urandom_range(16, 255));
      d = (i == 0) ? 16'h0001 : (i == 1) ? 16'h8000 : 16'($urandom);
      h = (i > 1 && i < 9) ? 1'($urandom) : 1'b0;
      word(a, d, h);
      if (!h) idle();
    end
    chk("pending", exp_q.size(), 0);
    av(1'b1, acp_pkg::CSR_STATUS, 32'h0000_0000, q);
    chk("status", q, 32'h0000_0000);
    // A host reset drops select after twelve bits; the device must discard them
    av(1'b0, acp_pkg::CSR_CMD, 32'h0012_3456, q);
    repeat (100) @(posedge clk_sys);
    rst_host <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst_host <= 1'b0;
    word(8'h3c, 16'h5a5a, 1'b1);
    idle();
    av(1'b1, acp_pkg::CSR_STATUS, 32'h0000_0000, q);
    chk("held", q, 32'h0000_0002);
    // Last pass: partial power-down with the sampling clock stopped
    for (int k = 0; k < 5; k++) begin
      d = (k == 0) ? 16'h0200 : (k == 1 || k == 4) ? 16'h0100 : (k == 3) ? 16'h0400 : 16'h0000;
      d[7:0] = 8'($urandom);
      sclk_run <= !k[2];
      word(acp_pkg::REG_POWER, d, 1'b0);
      idle();
      if (k[1]) av(1'b0, acp_pkg::CSR_CTRL, 32'h0000_0001, q);
      repeat (8) @(posedge clk_sys);
      chk("mode", {pdn_ch, pd_complete, pd_partial, data_valid}, {d[7:0], !(k[0] | k[2]), k[0] | k[2], 1'b0});
      sclk_run <= 1'b1;
      av(1'b1, acp_pkg::CSR_CTRL, 32'h0000_0000, q);
      chk("ctrl", q, 32'(k[1]));
      if (k[1]) av(1'b0, acp_pkg::CSR_CTRL, 32'h0000_0000, q);
      else word(acp_pkg::REG_POWER, 16'h0000, 1'b0);
      while (pd_complete === 1'b1 || pd_partial === 1'b1) @(posedge clk_sys);
      n = 0;
      while (data_valid !== 1'b1 && n < 3000) begin
        @(posedge clk_sys);
        n++;
      end
      chk("wake", 32'(n > wake_exp(!k[0] | k[2]) - 4 && n <= wake_exp(!k[0] | k[2]) + 3), 32'h1);
      idle();
    end
    for (int k = 0; k < 2; k++) begin
      word(acp_pkg::REG_POWER, 16'h01a5, 1'b0);
      idle();
      dl_n = 0;
      word(acp_pkg::REG_RESET, 16'h0001, 1'b0);
      idle();
      chk("soft reset", {pdn_ch, pd_partial, 32'(dl_n)}, {8'h00, 1'b0, 32'h1});
    end
    word(acp_pkg::REG_POWER, 16'h02ff, 1'b0);
    idle();
    dl_n = 0;
    av(1'b0, acp_pkg::CSR_CTRL, 32'h0000_0002, q);
    idle();
    chk("pin reset", {pdn_ch, pd_complete, dl_n > 0}, {8'h00, 1'b0, 1'b1});
    word(8'h3c, 16'h5a5a, 1'b0);
    idle();
    chk("pending", exp_q.size(), 0);
    wrap_up();
  end
endmodule : acp_tb
`default_nettype wire
